//--- pkg/sbs_defines.svh
// Constants of the burst memory pin-control block: sizes, register map, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

`define SBS_ADDR_W 10
`define SBS_DEPTH 1024
`define SBS_LANES 4
`define SBS_BEAT_LAST 2'h3
`define SBS_REG_CTRL 3'h0
`define SBS_REG_STATUS 3'h4
`define SBS_CTRL_SLEEP 0
`define SBS_CTRL_RST 1'b0
`define SBS_MODE_RST 1'b1
`define SBS_WAIT_RST 1'b1

`endif

//--- pkg/sbs_pkg.sv
// Types shared by the burst memory pin-control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sbs_pkg;

  typedef enum logic [3:0] {
    SBS_DESEL = 4'h1,
    SBS_READ = 4'h2,
    SBS_WRITE = 4'h4,
    SBS_SLEEP = 4'h8
  } sbs_state_e;

endpackage

//--- verilog/sbs_sram_ctrl.sv
// Flow-through burst static memory with pin-level control and an Avalon-MM status port.
// Assumes all pin inputs are synchronous to sys_clk; the bench resolves the shared data wires.
//
// Function
// - Selected only when all three selects active
// - Output enable low drives data and parity
// - Tristate during write data, emerging, deselected
// - Clock qualifier high holds address, burst and read data
// - Clock qualifier high never deselects
// - Sleep request enters data-preserving sleep
// - Write data captured on rising edge
// - Read returns word addressed at previous edge
// - Parity lines follow data, gated per byte
// - Strap low linear, high interleaved bursts
// - Advance steps counter, load takes address
// - Byte strobes active low, sampled on edge
// - Two low address bits seed burst counter
`timescale 1ns/1ps

`include "sbs_defines.svh"

module sbs_sram_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Memory control pins
  input wire logic select_low_a,
  input wire logic select_high,
  input wire logic select_low_b,
  input wire logic clock_qualifier_n,
  input wire logic write_strobe_n,
  input wire logic advance_or_load,
  input wire logic [`SBS_LANES-1:0] byte_write_n,
  input wire logic [`SBS_ADDR_W-1:0] addr,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_mode,
  // Data and parity lines, split into in, out and enable
  input wire logic [8*`SBS_LANES-1:0] data_in,
  output logic [8*`SBS_LANES-1:0] data_out,
  output logic data_oe,
  input wire logic [`SBS_LANES-1:0] parity_in,
  output logic [`SBS_LANES-1:0] parity_out,
  output logic parity_oe,
  // Avalon-MM status port
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int DW = 8 * `SBS_LANES;
  localparam int WW = 9 * `SBS_LANES;

  sbs_pkg::sbs_state_e state_ff;
  sbs_pkg::sbs_state_e nxt_state;
  logic [`SBS_ADDR_W-1:0] acc_addr_ff;
  logic [`SBS_ADDR_W-1:0] nxt_addr;
  logic [1:0] seed_ff;
  logic [1:0] nxt_seed;
  logic [1:0] beat_ff;
  logic [1:0] nxt_beat;
  logic [`SBS_LANES-1:0] wr_be_ff;
  logic [`SBS_LANES-1:0] nxt_be;
  logic [WW-1:0] rd_data_ff;
  logic data_oe_ff;
  logic parity_oe_ff;
  logic mode_ff;
  logic ctrl_sleep_ff;
  logic [31:0] avs_readdata_ff;
  logic avs_waitrequest_ff;
  logic [DW-1:0] rd_byte;
  logic [`SBS_LANES-1:0] rd_par;
  logic selected;
  logic sleep_any;
  logic in_burst;
  logic wr_commit;
  logic rd_capture;
  logic [DW-1:0] wr_data_bits;

  // Linear adds the beat to the seed, interleaved xors it; both wrap in the group of four
  function automatic logic [1:0] burst_step(input logic [1:0] seed, input logic [1:0] beat,
                                            input logic interleaved);
    burst_step = interleaved ? (seed ^ beat) : 2'(seed + beat);
  endfunction

  // Spreads one mask bit per lane over the eight data bits of that lane
  function automatic logic [DW-1:0] lane_bits(input logic [`SBS_LANES-1:0] mask);
    lane_bits = '0;
    for (int i = 0; i < `SBS_LANES; i++) begin
      lane_bits[8*i+:8] = {8{mask[i]}};
    end
  endfunction

  assign selected = !select_low_a && select_high && !select_low_b;
  assign sleep_any = sleep_request || ctrl_sleep_ff;
  assign in_burst = (state_ff == sbs_pkg::SBS_READ) || (state_ff == sbs_pkg::SBS_WRITE);
  // A write pending when sleep starts is dropped, as any access cut by sleep is
  assign wr_commit = (state_ff == sbs_pkg::SBS_WRITE) && !clock_qualifier_n && !sleep_any;
  assign rd_capture = (nxt_state == sbs_pkg::SBS_READ) && !clock_qualifier_n && !sleep_any;
  // Data bits of the lanes that the pending write beat really updates
  assign wr_data_bits = lane_bits(~wr_be_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_addr = acc_addr_ff;
    nxt_seed = seed_ff;
    nxt_beat = beat_ff;
    nxt_be = wr_be_ff;
    if (sleep_any) begin
      nxt_state = sbs_pkg::SBS_SLEEP;
    end else if (!clock_qualifier_n) begin
      if (state_ff == sbs_pkg::SBS_SLEEP) begin
        nxt_state = sbs_pkg::SBS_DESEL;
      end else if (!advance_or_load) begin
        if (selected) begin
          nxt_state = write_strobe_n ? sbs_pkg::SBS_READ : sbs_pkg::SBS_WRITE;
          nxt_addr = addr;
          nxt_seed = addr[1:0];
          nxt_beat = 2'h0;
          nxt_be = byte_write_n;
        end else begin
          nxt_state = sbs_pkg::SBS_DESEL;
        end
      end else if (in_burst && beat_ff != `SBS_BEAT_LAST) begin
        nxt_beat = 2'(beat_ff + 2'h1);
        nxt_addr = {acc_addr_ff[`SBS_ADDR_W-1:2], burst_step(seed_ff, nxt_beat, mode_ff)};
        nxt_be = byte_write_n;
      end else begin
        // Advancing past the fourth beat or while idle gives no access
        nxt_state = sbs_pkg::SBS_DESEL;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= sbs_pkg::SBS_DESEL;
      acc_addr_ff <= '0;
      seed_ff <= 2'h0;
      beat_ff <= 2'h0;
      wr_be_ff <= '1;
    end else begin
      state_ff <= nxt_state;
      acc_addr_ff <= nxt_addr;
      seed_ff <= nxt_seed;
      beat_ff <= nxt_beat;
      wr_be_ff <= nxt_be;
    end
  end

  // Strap is resampled every cycle, so a change takes effect on the next advance step, even mid-burst
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff <= `SBS_MODE_RST;
    end else begin
      mode_ff <= burst_mode;
    end
  end

  // One storage array per byte lane: eight data bits plus the lane's parity bit
  for (genvar g = 0; g < `SBS_LANES; g++) begin : g_lane
    logic [8:0] lane_mem [0:`SBS_DEPTH-1];
    logic [8:0] wr_lane;
    logic lane_wr;
    assign wr_lane = {parity_in[g], data_in[8*g+:8]};
    assign lane_wr = wr_commit && !wr_be_ff[g];
    always_ff @(posedge sys_clk) begin
      if (lane_wr) begin
        lane_mem[acc_addr_ff] <= wr_lane;
      end
    end
    // Bypass lets a read right after a write to the same word see the new bytes
    assign {rd_par[g], rd_byte[8*g+:8]} = (lane_wr && acc_addr_ff == nxt_addr) ?
                                          wr_lane : lane_mem[nxt_addr];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else if (rd_capture) begin
      rd_data_ff <= {rd_par, rd_byte};
    end
  end

  // Output enable is sampled, so a change on its pin shows one edge later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_oe_ff <= 1'b0;
      parity_oe_ff <= 1'b0;
    end else begin
      data_oe_ff <= (nxt_state == sbs_pkg::SBS_READ) && !output_enable_n;
      parity_oe_ff <= (nxt_state == sbs_pkg::SBS_READ) && !output_enable_n;
    end
  end

  assign data_out = rd_data_ff[DW-1:0];
  assign parity_out = rd_data_ff[WW-1:DW];
  assign data_oe = data_oe_ff;
  assign parity_oe = parity_oe_ff;

  // Bus slave answers every request after exactly one wait cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest_ff <= `SBS_WAIT_RST;
    end else begin
      avs_waitrequest_ff <= !((avs_read || avs_write) && avs_waitrequest_ff);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_sleep_ff <= `SBS_CTRL_RST;
    end else if (avs_write && !avs_waitrequest_ff && avs_address == `SBS_REG_CTRL) begin
      ctrl_sleep_ff <= avs_writedata[`SBS_CTRL_SLEEP];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata_ff <= 32'h0;
    end else if (avs_read && avs_waitrequest_ff) begin
      case (avs_address)
        `SBS_REG_CTRL: avs_readdata_ff <= {31'h0, ctrl_sleep_ff};
        `SBS_REG_STATUS: avs_readdata_ff <= {24'h0, mode_ff, data_oe_ff, acc_addr_ff[1:0],
                                             state_ff};
        default: avs_readdata_ff <= 32'h0;
      endcase
    end
  end

  assign avs_readdata = avs_readdata_ff;
  assign avs_waitrequest = avs_waitrequest_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_drive_only_read: assert property (
    data_oe_ff |-> state_ff == sbs_pkg::SBS_READ
  ) else $error("data driven outside a read");

  a_write_tristate: assert property (
    state_ff == sbs_pkg::SBS_WRITE |-> !data_oe_ff && !parity_oe_ff
  ) else $error("lines driven during write data");

  a_read_drives: assert property (
    (!clock_qualifier_n && !sleep_any && !advance_or_load && selected && write_strobe_n
     && !output_enable_n && state_ff != sbs_pkg::SBS_SLEEP) |=> data_oe_ff && parity_oe_ff
  ) else $error("selected read with enable low not driven");

  a_desel_select: assert property (
    (!clock_qualifier_n && !sleep_any && !advance_or_load && !selected
     && state_ff != sbs_pkg::SBS_SLEEP) |=> state_ff == sbs_pkg::SBS_DESEL && !data_oe_ff
  ) else $error("unselected load did not deselect");

  a_qualifier_hold: assert property (
    (clock_qualifier_n && !sleep_any) |=> $stable(state_ff) && $stable(rd_data_ff)
      && $stable(acc_addr_ff) && $stable(beat_ff)
  ) else $error("state changed with clock qualifier high");

  a_sleep_enter: assert property (
    sleep_request |=> state_ff == sbs_pkg::SBS_SLEEP && !data_oe_ff
  ) else $error("sleep request not obeyed");

  a_write_readback: assert property (
    (wr_commit && !advance_or_load && selected && write_strobe_n && addr == acc_addr_ff)
      |=> ((data_out ^ $past(data_in)) & $past(wr_data_bits)) == '0
  ) else $error("read after write returned wrong data");

  a_parity_readback: assert property (
    (wr_commit && !advance_or_load && selected && write_strobe_n && addr == acc_addr_ff)
      |=> ((parity_out ^ $past(parity_in)) & ~$past(wr_be_ff)) == '0
  ) else $error("written parity lanes read back wrong");

  a_linear_step: assert property (
    (in_burst && advance_or_load && !clock_qualifier_n && !sleep_any && !mode_ff
     && beat_ff != 2'h3) |=> acc_addr_ff[1:0] == 2'($past(seed_ff) + $past(beat_ff) + 2'h1)
  ) else $error("linear burst address wrong");

  a_interleave_step: assert property (
    (in_burst && advance_or_load && !clock_qualifier_n && !sleep_any && mode_ff
     && beat_ff != 2'h3) |=> acc_addr_ff[1:0] == ($past(seed_ff) ^ 2'($past(beat_ff) + 2'h1))
  ) else $error("interleaved burst address wrong");

  a_burst_limit: assert property (
    (beat_ff == 2'h3 && advance_or_load && !clock_qualifier_n && !sleep_any)
      |=> state_ff == sbs_pkg::SBS_DESEL
  ) else $error("burst ran past four beats");

  a_load_capture: assert property (
    (!clock_qualifier_n && !sleep_any && !advance_or_load && selected
     && state_ff != sbs_pkg::SBS_SLEEP) |=> acc_addr_ff == $past(addr) && beat_ff == 2'h0
      && seed_ff == $past(addr[1:0])
  ) else $error("load did not take the address");

  a_sleep_exit: assert property (
    (state_ff == sbs_pkg::SBS_SLEEP && !sleep_any && !clock_qualifier_n) |=> state_ff == sbs_pkg::SBS_DESEL
  ) else $error("sleep exit did not pass through deselect");

  a_enable_high: assert property (
    output_enable_n |=> !data_oe_ff && !parity_oe_ff
  ) else $error("lines driven with enable high");

  a_parity_pair: assert property (
    data_oe_ff == parity_oe_ff
  ) else $error("parity drive differs from data drive");

  a_desel_quiet: assert property (
    state_ff == sbs_pkg::SBS_DESEL |-> !data_oe_ff && !parity_oe_ff
  ) else $error("lines driven while deselected");

  a_read_hold: assert property (
    (state_ff == sbs_pkg::SBS_READ && clock_qualifier_n && !sleep_any)
      |=> $stable(data_out) && $stable(parity_out)
  ) else $error("read data moved during a stretched cycle");

  // Each beat of a write burst takes fresh byte strobes
  a_beat_strobes: assert property (
    (in_burst && advance_or_load && !clock_qualifier_n && !sleep_any && beat_ff != 2'h3)
      |=> wr_be_ff == $past(byte_write_n)
  ) else $error("byte strobes not taken on advance");

  a_ctrl_write: assert property (
    (avs_write && !avs_waitrequest_ff && avs_address == `SBS_REG_CTRL)
      |=> ctrl_sleep_ff == $past(avs_writedata[`SBS_CTRL_SLEEP])
  ) else $error("sleep control write lost");

  a_wait_answer: assert property (
    ((avs_read || avs_write) && avs_waitrequest_ff) |=> !avs_waitrequest_ff
  ) else $error("bus request not answered after one wait");

  a_wait_pulse: assert property (
    !avs_waitrequest_ff |=> avs_waitrequest_ff
  ) else $error("wait release longer than one cycle");

  c_full_read_burst: cover property (state_ff == sbs_pkg::SBS_READ && beat_ff == 2'h3);
  c_byte_write: cover property (wr_commit && wr_be_ff != 4'h0 && wr_be_ff != 4'hF);
  c_write_commit: cover property (wr_commit ##1 state_ff == sbs_pkg::SBS_READ);
  c_stall_read: cover property (state_ff == sbs_pkg::SBS_READ && clock_qualifier_n [*2]);
  c_sleep_exit: cover property (state_ff == sbs_pkg::SBS_SLEEP ##1
                                state_ff == sbs_pkg::SBS_DESEL);

endmodule

//--- verification/sbs_host_bus.sv
// Controller side of the shared data and parity wires of the burst memory.
// Assumes the bench supplies the controller's write drive and enable.
`timescale 1ns/1ps

module sbs_host_bus (
  // Clock
  input wire logic sys_clk,
  // Device drive
  input wire logic [31:0] dev_d,
  input wire logic [3:0] dev_p,
  input wire logic dev_oe,
  // Controller drive
  input wire logic [31:0] host_d,
  input wire logic [3:0] host_p,
  input wire logic host_oe,
  // Resolved wires
  output logic [31:0] bus_d,
  output logic [3:0] bus_p,
  output logic clash
);
  logic [35:0] last_ff;

  // No pull on these wires: released, they show the inverse of the last level
  always_comb begin
    {bus_d, bus_p} = dev_oe ? {dev_d, dev_p} : (host_oe ? {host_d, host_p} : ~last_ff);
  end

  always_ff @(posedge sys_clk) begin
    last_ff <= {bus_d, bus_p};
  end

  // Write data must only go out while the device has released the wires
  assign clash = dev_oe & host_oe;
endmodule

//--- verification/sync_burst_sram_pin_control_tb.sv
// Bench for sbs_sram_ctrl: bursts, byte writes, output masking, sleep, status port.
// Assumes sbs_host_bus resolves the shared data and parity wires.
`timescale 1ns/1ps

module sync_burst_sram_pin_control_tb;
  localparam logic [9:0] BASE = 10'h0F5;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sa_n = 1'b1, sh = 1'b0, sb_n = 1'b1, qual_n = 1'b0, we_n = 1'b1, adv = 1'b0;
  logic oe_n = 1'b1, sleep_req = 1'b0, mode = 1'b0, hoe = 1'b0, data_oe, parity_oe, clash;
  logic [3:0] bw_n = 4'hF, hp = 4'h0, bus_p, parity_out;
  logic [9:0] addr = 10'h000;
  logic [31:0] hd = 32'h0, bus_d, data_out, rd, avs_readdata, avs_wd = 32'h0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] dw [4];
  logic [3:0] pw [4];
  int fails = 0, cmp_count = 0;

  always #5 sys_clk = ~sys_clk;

  sbs_sram_ctrl uut (.sys_clk(sys_clk), .rst(rst), .select_low_a(sa_n), .select_high(sh),
    .select_low_b(sb_n), .clock_qualifier_n(qual_n), .write_strobe_n(we_n),
    .advance_or_load(adv), .byte_write_n(bw_n), .addr(addr), .output_enable_n(oe_n),
    .sleep_request(sleep_req), .burst_mode(mode), .data_in(bus_d), .data_out(data_out),
    .data_oe(data_oe), .parity_in(bus_p), .parity_out(parity_out), .parity_oe(parity_oe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_wd), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  sbs_host_bus host (.sys_clk(sys_clk), .dev_d(data_out), .dev_p(parity_out), .dev_oe(data_oe),
    .host_d(hd), .host_p(hp), .host_oe(hoe), .bus_d(bus_d), .bus_p(bus_p), .clash(clash));

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // One pin command, taken at the next edge; sel is {sa_n, sh, sb_n}
  task automatic cmd(input logic [2:0] sel, input logic load, input logic wr,
                     input logic [9:0] a = BASE, input logic [3:0] bw = 4'hF);
    {sa_n, sh, sb_n} <= sel;
    adv <= ~load;
    we_n <= ~wr;
    addr <= a;
    bw_n <= bw;
    @(posedge sys_clk);
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_wd <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk(n < 20, "bus request unanswered");
    @(posedge sys_clk);
  endtask

  task automatic burst_write;
    for (int i = 0; i < 4; i++) begin
      dw[i] = 32'h1357_9BDF + 32'h1111_1111 * i;
      pw[i] = 4'(i + 5);
    end
    oe_n <= 1'b0;
    cmd(3'b010, 1'b1, 1'b1, BASE, 4'h0);
    for (int i = 0; i < 4; i++) begin
      hd <= dw[i];
      hp <= pw[i];
      hoe <= 1'b1;
      chk(data_oe === 1'b0 && parity_oe === 1'b0, "driving during write");
      cmd(i < 3 ? 3'b010 : 3'b110, i == 3, 1'b1, BASE, 4'h0);
    end
    cmd(3'b010, 1'b1, 1'b1, BASE + 10'h1, 4'hA);
    hd <= 32'hFFFF_FFFF;
    hp <= 4'hF;
    mode <= 1'b1;
    cmd(3'b010, 1'b1, 1'b0, BASE + 10'h1);
    hoe <= 1'b0;
    dw[1] = (dw[1] & 32'hFF00_FF00) | 32'h00FF_00FF;
    pw[1] = (pw[1] & 4'hA) | 4'h5;
  endtask

  // Interleaved read from low bits 01, stalled by the qualifier mid-burst
  task automatic burst_read;
    int ord [4] = '{0, 3, 2, 1};
    cmd(3'b010, 1'b1, 1'b0);
    chk(data_oe === 1'b1 && data_out === dw[1] && parity_out === pw[1], "byte write wrong");
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        qual_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        qual_n <= 1'b0;
      end
      cmd(3'b010, 1'b0, 1'b0);
      chk(data_oe === 1'b1 && data_out === dw[ord[i]] && parity_out === pw[ord[i]],
          "burst word wrong");
    end
    cmd(3'b010, 1'b0, 1'b0);
    chk(data_oe === 1'b0, "fifth beat driven");
  endtask

  task automatic masking;
    for (int k = 0; k < 3; k++) begin
      cmd(3'b010 ^ (3'b001 << k), 1'b1, 1'b0);
      cmd(3'b110, 1'b1, 1'b0);
      chk(data_oe === 1'b0, "driving while deselected");
    end
    oe_n <= 1'b1;
    cmd(3'b010, 1'b1, 1'b0);
    cmd(3'b110, 1'b1, 1'b0);
    chk(data_oe === 1'b0 && parity_oe === 1'b0, "driving with enable high");
    oe_n <= 1'b0;
  endtask

  task automatic sleep_and_status;
    sleep_req <= 1'b1;
    cmd(3'b010, 1'b1, 1'b0);
    cmd(3'b110, 1'b1, 1'b0);
    chk(data_oe === 1'b0, "read taken asleep");
    bus(1'b0, 3'h4, 32'h0);
    chk(rd[3:0] === 4'h8, "status not asleep");
    sleep_req <= 1'b0;
    bus(1'b1, 3'h0, 32'h1);
    bus(1'b0, 3'h4, 32'h0);
    chk(rd[3:0] === 4'h8, "register sleep not shown");
    bus(1'b1, 3'h0, 32'h0);
    bus(1'b0, 3'h2, 32'h0);
    chk(rd === 32'h0, "unmapped read not zero");
    cmd(3'b110, 1'b1, 1'b0);
    cmd(3'b010, 1'b1, 1'b0);
    cmd(3'b110, 1'b1, 1'b0);
    chk(data_oe === 1'b1 && data_out === dw[0], "word lost in sleep");
  endtask

  task automatic test_done;
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    if (clash === 1'b1) begin
      fails++;
      $display("[FAIL] %0t both sides drive the wires", $time);
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    burst_write();
    burst_read();
    masking();
    sleep_and_status();
    test_done();
  end

  // The whole sequence needs some 55 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    test_done();
  end
endmodule
